// [btsg_pkg.sv]
// package: register map, field positions, reset values and states of the buzzer tone generator
`default_nettype none
package btsg_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_TONE_DIVISOR_LOW    = 16'ha128;
    localparam logic [15:0] IDX_FRAME_PULSE_COUNTS  = 16'ha129;
    localparam logic [15:0] IDX_SESSION_FRAME_COUNT = 16'ha12a;
    localparam logic [15:0] IDX_TONE_CONFIG_CONTROL = 16'ha12b;
    localparam logic [15:0] IDX_SESSION_MUTE_FRAME  = 16'ha12c;
    localparam logic [15:0] IDX_IRQ_STATUS          = 16'ha12d;
    localparam logic [15:0] IDX_IRQ_MASK            = 16'ha12e;
    // reset values
    localparam logic [7:0] RST_TONE_DIVISOR = 8'h10;
    localparam logic [7:0] RST_FRAME_PULSES = 8'hf0;
    localparam logic [7:0] RST_SESSION_FRMS = 8'h80;
    localparam logic [7:0] RST_CONFIG       = 8'h00;
    localparam logic [7:0] RST_MUTE_FRAME   = 8'hff;
    localparam logic [1:0] RST_IRQ          = 2'h0;
    // config register bit positions
    localparam int CFG_ENABLE  = 7;
    localparam int CFG_IRQ_EN  = 6;
    localparam int CFG_CSEL    = 5;
    localparam int CFG_DIV8    = 4;
    localparam int CFG_INVERT  = 3;
    localparam int CFG_REPEAT  = 2;
    localparam int CFG_FLAG    = 1;
    localparam int CFG_GO_BUSY = 0;
    // frame register nibbles
    localparam int FRM_ON_LSB     = 4;
    localparam int FRM_SILENT_LSB = 0;
    // irq status bits
    localparam int IRQ_SESSION_END   = 0;
    localparam int IRQ_SESSION_START = 1;
    localparam int IRQ_W             = 2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int DIV_W = 9;

    typedef enum logic [1:0] {
        BTSG_IDLE = 2'b01,
        BTSG_RUN  = 2'b10
    } btsg_state_t;

    function automatic logic btsg_word_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
        btsg_word_hit = (addr == {14'h0000, idx, 2'h0});
    endfunction : btsg_word_hit
endpackage : btsg_pkg
`default_nettype wire

// [btsg_tone_if.sv]
// interface: tone divider control and pulse strobes
`timescale 1ns/1ps
`default_nettype none
interface btsg_tone_if;
    import btsg_pkg::*;
    logic              tick;
    logic              run;
    logic [DIV_W-1:0]  divisor;
    logic              wave;
    logic              pulse_end;
    modport ctl (output tick, output run, output divisor, input wave, input pulse_end);
    modport gen (input tick, input run, input divisor, output wave, output pulse_end);
endinterface : btsg_tone_if
`default_nettype wire

// [btsg_osc_sync.sv]
// module: synchronises oscillator pins and gives one-cycle rising-edge enables
`timescale 1ns/1ps
`default_nettype none
module btsg_osc_sync #(
    parameter int N = 2
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // oscillator pins and edge enables
    input  wire logic [N-1:0] osc_pin,
    output logic      [N-1:0] osc_rise
);
    import btsg_pkg::*;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_osc
            logic s1_r;
            logic s2_r;
            logic s3_r;
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end else begin
                    s1_r <= osc_pin[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end
            assign osc_rise[i] = s2_r & ~s3_r;
        end
    endgenerate
endmodule : btsg_osc_sync
`default_nettype wire

// [btsg_tone_div.sv]
// module: divides the tone clock enable by the 9-bit divisor into a square wave
`timescale 1ns/1ps
`default_nettype none
module btsg_tone_div (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // control and strobes
    btsg_tone_if.gen  tone
);
    import btsg_pkg::*;

    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    // first pulse waits for a tick so every period is whole
    logic             armed_r;
    wire  [DIV_W-1:0] div_eff  = (tone.divisor == '0) ? 9'h001 : tone.divisor;
    wire  [DIV_W-1:0] half_cnt = DIV_W'((10'(div_eff) + 10'h001) >> 1);
    wire              last_cnt = (cnt_r == div_eff - 9'h001);

    assign cnt_nxt        = !tone.run ? '0 : !tone.tick ? cnt_r : (!armed_r | last_cnt) ? '0 : cnt_r + 9'h001;
    assign tone.pulse_end = tone.run & tone.tick & armed_r & last_cnt;
    assign tone.wave      = tone.run & armed_r & (cnt_r < half_cnt);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r   <= '0;
            armed_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            armed_r <= tone.run & (armed_r | tone.tick);
        end
    end

    a_half_wave_high: assert property (@(posedge clk) disable iff (sys_rst)
        tone.run && armed_r && cnt_r == '0 |-> tone.wave)
        else $error("tone wave not high at period start");
endmodule : btsg_tone_div
`default_nettype wire

// [btsg_buzzer.sv]
// module: buzzer tone, frame and session generator with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - frame sends upper-nibble count of tone pulses, then lower-nibble count of silent pulses
// - session lasts the programmed 8-bit number of frames
// - tone period is tone clock divided by 9-bit divisor, bit 8 in config
// - writing one to session go starts a session
// - session go clears itself when its session finishes
// - repeat bit set runs sessions back to back
// - repeat bit clear gives exactly one session per go command
// - session-end interrupt only when its enable is one, in both modes
// - session end with interrupt enable one sets flag and interrupt; flag stays until software clears it
// - config bit 0 reads one while output active, zero when idle
// - clock select zero picks fast oscillator, one picks slow oscillator
// - invert bit one inverts the output pin
// - controller works only while enable bit is one
// - frames at and beyond the mute frame number are silent, counting from frame zero
module btsg_buzzer (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    // oscillator pins
    input  wire logic                           fast_internal_osc,
    input  wire logic                           slow_internal_osc,
    // axi4-lite write address and data
    input  wire logic [btsg_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [btsg_pkg::DATA_W-1:0]    s_axi_wdata,
    input  wire logic [btsg_pkg::DATA_W/8-1:0]  s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    // axi4-lite read
    input  wire logic [btsg_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [btsg_pkg::DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    // buzzer pin and interrupt
    output logic                                tone_output_pin,
    output logic                                irq
);
    import btsg_pkg::*;

    // registers
    logic [7:0]        divisor_r;
    logic [7:0]        frame_r;
    logic [7:0]        frames_r;
    logic [7:0]        mute_r;
    logic              en_r;
    logic              irq_en_r;
    logic              csel_r;
    logic              div8_r;
    logic              invert_r;
    logic              repeat_r;
    logic              flag_r;
    logic              flag_nxt;
    logic              go_r;
    logic              go_nxt;
    logic [IRQ_W-1:0]  stat_r;
    logic [IRQ_W-1:0]  stat_nxt;
    logic [IRQ_W-1:0]  mask_r;
    btsg_state_t       state_r;
    btsg_state_t       state_nxt;
    logic [4:0]        pulse_cnt_r;
    logic [4:0]        pulse_cnt_nxt;
    logic [7:0]        frame_cnt_r;
    logic [7:0]        frame_cnt_nxt;
    logic              pin_nxt;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [DATA_W-1:0] rdata_r;

    // oscillator edges and tone divider
    logic [1:0] osc_rise;
    btsg_tone_if tone ();

    btsg_osc_sync #(.N(2)) u_osc_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .osc_pin  ({slow_internal_osc, fast_internal_osc}),
        .osc_rise (osc_rise)
    );

    btsg_tone_div u_tone_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tone    (tone.gen)
    );

    wire running = (state_r == BTSG_RUN);
    assign tone.tick    = csel_r ? osc_rise[1] : osc_rise[0];
    assign tone.divisor = {div8_r, divisor_r};
    assign tone.run     = running;

    // bus decode
    wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
    wire wr_ok   = wr_fire & s_axi_wstrb[0];
    wire rd_fire = s_axi_arvalid & ~rvalid_r;

    wire hw_div   = btsg_word_hit(s_axi_awaddr, IDX_TONE_DIVISOR_LOW);
    wire hw_frame = btsg_word_hit(s_axi_awaddr, IDX_FRAME_PULSE_COUNTS);
    wire hw_frms  = btsg_word_hit(s_axi_awaddr, IDX_SESSION_FRAME_COUNT);
    wire hw_cfg   = btsg_word_hit(s_axi_awaddr, IDX_TONE_CONFIG_CONTROL);
    wire hw_mute  = btsg_word_hit(s_axi_awaddr, IDX_SESSION_MUTE_FRAME);
    wire hw_stat  = btsg_word_hit(s_axi_awaddr, IDX_IRQ_STATUS);
    wire hw_mask  = btsg_word_hit(s_axi_awaddr, IDX_IRQ_MASK);
    wire hw_any   = hw_div | hw_frame | hw_frms | hw_cfg | hw_mute | hw_stat | hw_mask;

    wire hr_div   = btsg_word_hit(s_axi_araddr, IDX_TONE_DIVISOR_LOW);
    wire hr_frame = btsg_word_hit(s_axi_araddr, IDX_FRAME_PULSE_COUNTS);
    wire hr_frms  = btsg_word_hit(s_axi_araddr, IDX_SESSION_FRAME_COUNT);
    wire hr_cfg   = btsg_word_hit(s_axi_araddr, IDX_TONE_CONFIG_CONTROL);
    wire hr_mute  = btsg_word_hit(s_axi_araddr, IDX_SESSION_MUTE_FRAME);
    wire hr_stat  = btsg_word_hit(s_axi_araddr, IDX_IRQ_STATUS);
    wire hr_mask  = btsg_word_hit(s_axi_araddr, IDX_IRQ_MASK);
    wire hr_any   = hr_div | hr_frame | hr_frms | hr_cfg | hr_mute | hr_stat | hr_mask;

    wire wr_cfg   = wr_ok & hw_cfg;
    wire [7:0] wb = s_axi_wdata[7:0];

    wire [7:0] cfg_rd = {en_r, irq_en_r, csel_r, div8_r, invert_r, repeat_r, flag_r, running};
    wire [7:0] rd_byte = hr_div   ? divisor_r :
                         hr_frame ? frame_r :
                         hr_frms  ? frames_r :
                         hr_cfg   ? cfg_rd :
                         hr_mute  ? mute_r :
                         hr_stat  ? {6'h00, stat_r} :
                         hr_mask  ? {6'h00, mask_r} : 8'h00;

    // frame and session sequencing
    wire [3:0] on_pulses     = frame_r[FRM_ON_LSB +: 4];
    wire [3:0] silent_pulses = frame_r[FRM_SILENT_LSB +: 4];
    wire [4:0] frame_len     = {1'b0, on_pulses} + {1'b0, silent_pulses};
    wire [4:0] pulse_inc     = pulse_cnt_r + 5'h01;
    wire       frame_end     = tone.pulse_end & (pulse_inc >= frame_len);
    wire       last_frame    = (frame_cnt_r == frames_r - 8'h01);
    wire       session_end   = running & frame_end & last_frame;
    wire       session_start = (state_r == BTSG_IDLE) & (state_nxt == BTSG_RUN);
    wire       muted         = (frame_cnt_r >= mute_r);
    wire       sounding      = running & en_r & ({1'b0, on_pulses} > pulse_cnt_r) & ~muted;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BTSG_IDLE: begin
                if (en_r && (go_r || repeat_r)) begin
                    state_nxt = BTSG_RUN;
                end
            end
            BTSG_RUN: begin
                if (!en_r) begin
                    state_nxt = BTSG_IDLE;
                end else if (session_end && !repeat_r) begin
                    state_nxt = BTSG_IDLE;
                end
            end
            default: state_nxt = BTSG_IDLE;
        endcase
    end

    assign pulse_cnt_nxt = !running ? 5'h00 : frame_end ? 5'h00 : tone.pulse_end ? pulse_inc : pulse_cnt_r;
    assign frame_cnt_nxt = !running ? 8'h00 : session_end ? 8'h00 :
                           frame_end ? frame_cnt_r + 8'h01 : frame_cnt_r;
    assign go_nxt   = (wr_cfg & wb[CFG_GO_BUSY]) ? 1'b1 : (session_end | ~en_r) ? 1'b0 : go_r;
    assign flag_nxt = (session_end & irq_en_r) ? 1'b1 : (wr_cfg & ~wb[CFG_FLAG]) ? 1'b0 : flag_r;
    assign stat_nxt = (stat_r & ~((rd_fire & hr_stat) ? {IRQ_W{1'b1}} : {IRQ_W{1'b0}}))
                    | {session_start, session_end & irq_en_r};
    assign pin_nxt  = invert_r ^ (sounding & tone.wave);

    // handshake outputs
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign irq           = irq_en_r & |(stat_r & mask_r);

    // bus response flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= '0;
        end else begin
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= hw_any ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_r <= 1'b1;
                rresp_r  <= hr_any ? RESP_OKAY : RESP_SLVERR;
                rdata_r  <= {24'h000000, rd_byte};
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // software registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            divisor_r <= RST_TONE_DIVISOR;
            frame_r   <= RST_FRAME_PULSES;
            frames_r  <= RST_SESSION_FRMS;
            mute_r    <= RST_MUTE_FRAME;
            {en_r, irq_en_r, csel_r, div8_r, invert_r, repeat_r} <= RST_CONFIG[CFG_ENABLE:CFG_REPEAT];
            mask_r    <= RST_IRQ;
        end else if (wr_ok) begin
            if (hw_div)   divisor_r <= wb;
            if (hw_frame) frame_r   <= wb;
            if (hw_frms)  frames_r  <= wb;
            if (hw_mute)  mute_r    <= wb;
            if (hw_mask)  mask_r    <= wb[IRQ_W-1:0];
            if (hw_cfg)   {en_r, irq_en_r, csel_r, div8_r, invert_r, repeat_r} <= wb[CFG_ENABLE:CFG_REPEAT];
        end
    end

    // sequencer state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r         <= BTSG_IDLE;
            pulse_cnt_r     <= 5'h00;
            frame_cnt_r     <= 8'h00;
            go_r            <= RST_CONFIG[CFG_GO_BUSY];
            flag_r          <= RST_CONFIG[CFG_FLAG];
            stat_r          <= RST_IRQ;
            tone_output_pin <= 1'b0;
        end else begin
            state_r         <= state_nxt;
            pulse_cnt_r     <= pulse_cnt_nxt;
            frame_cnt_r     <= frame_cnt_nxt;
            go_r            <= go_nxt;
            flag_r          <= flag_nxt;
            stat_r          <= stat_nxt;
            tone_output_pin <= pin_nxt;
        end
    end

    // checks
    a_pin_idle_level: assert property (@(posedge clk) disable iff (sys_rst)
        !en_r |=> tone_output_pin == $past(invert_r))
        else $error("disabled output not at inactive level");

    a_go_starts_run: assert property (@(posedge clk) disable iff (sys_rst)
        en_r && go_r && state_r == BTSG_IDLE |=> state_r == BTSG_RUN)
        else $error("session go did not start a session");

    a_go_self_clear: assert property (@(posedge clk) disable iff (sys_rst)
        session_end && !wr_cfg |=> !go_r)
        else $error("session go not cleared at session end");

    a_repeat_restart: assert property (@(posedge clk) disable iff (sys_rst)
        session_end && repeat_r && en_r |=> running && frame_cnt_r == 8'h00 && pulse_cnt_r == 5'h00)
        else $error("repeat mode did not restart session");

    a_single_session: assert property (@(posedge clk) disable iff (sys_rst)
        session_end && !repeat_r && !wr_cfg |=> state_r == BTSG_IDLE ##1 state_r == BTSG_IDLE)
        else $error("single session mode did not stop");

    a_flag_on_end: assert property (@(posedge clk) disable iff (sys_rst)
        session_end && irq_en_r |=> flag_r && stat_r[IRQ_SESSION_END])
        else $error("session end flag not set");

    a_no_flag_disabled: assert property (@(posedge clk) disable iff (sys_rst)
        !irq_en_r && !flag_r |=> !flag_r)
        else $error("flag set with session end interrupt disabled");

    a_mute_silent: assert property (@(posedge clk) disable iff (sys_rst)
        running && muted |=> tone_output_pin == $past(invert_r))
        else $error("muted frame produced sound");

    a_gap_silent: assert property (@(posedge clk) disable iff (sys_rst)
        running && pulse_cnt_r >= {1'b0, on_pulses} |=> tone_output_pin == $past(invert_r))
        else $error("silent part of frame produced sound");

    a_disable_stops: assert property (@(posedge clk) disable iff (sys_rst)
        !en_r |=> state_r == BTSG_IDLE ##1 pulse_cnt_r == 5'h00 && frame_cnt_r == 8'h00)
        else $error("disabled controller kept running");

    c_repeat_session: cover property (@(posedge clk) disable iff (sys_rst)
        session_end && repeat_r);
    c_muted_frame: cover property (@(posedge clk) disable iff (sys_rst)
        running && muted && tone.pulse_end);
    c_irq_raised: cover property (@(posedge clk) disable iff (sys_rst)
        !irq ##1 irq);
endmodule : btsg_buzzer
`default_nettype wire

// [btsg_buzzer_model.sv]
// buzzer model: counts tone pulses and measures their period and high time
`timescale 1ns/1ps
`default_nettype none
module btsg_buzzer_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // buzzer pin and measurements
    input  wire logic        pin,
    output logic      [15:0] rises,
    output logic      [15:0] period,
    output logic      [15:0] high_w
);
    logic [15:0] cnt_r;
    logic [15:0] rise_at_r;
    logic        prev_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r     <= 16'h0000;
            rise_at_r <= 16'h0000;
            prev_r    <= 1'b0;
            rises     <= 16'h0000;
            period    <= 16'h0000;
            high_w    <= 16'h0000;
        end else begin
            cnt_r  <= cnt_r + 16'h0001;
            prev_r <= pin;
            if (pin && !prev_r) begin
                rises     <= rises + 16'h0001;
                period    <= cnt_r - rise_at_r;
                rise_at_r <= cnt_r;
            end
            if (!pin && prev_r) begin
                high_w <= cnt_r - rise_at_r;
            end
        end
    end
endmodule : btsg_buzzer_model
`default_nettype wire

// [btsg_buzzer_tb_top.sv]
// testbench: register access, sessions, tone timing, interrupts and polarity
`timescale 1ns/1ps
`default_nettype none
module btsg_buzzer_tb_top;
    import btsg_pkg::*;
    localparam int FAST_T = 4;
    localparam int SLOW_T = 8;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [2:0]  osc_cnt = 3'h0;
    logic        fast_osc = 1'b0;
    logic        slow_osc = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        tone_output_pin, irq;
    logic [15:0] rises, period, high_w;
    int          fail_count = 0;
    int          n_compared = 0;
    logic [15:0] ri[7] = '{IDX_TONE_DIVISOR_LOW, IDX_FRAME_PULSE_COUNTS, IDX_SESSION_FRAME_COUNT,
                           IDX_TONE_CONFIG_CONTROL, IDX_SESSION_MUTE_FRAME, IDX_IRQ_STATUS, IDX_IRQ_MASK};
    logic [7:0]  rv[7] = '{RST_TONE_DIVISOR, RST_FRAME_PULSES, RST_SESSION_FRMS, RST_CONFIG,
                           RST_MUTE_FRAME, 8'h00, 8'h00};
    logic [7:0]  mv[3] = '{8'h01, 8'h00, 8'hff};
    logic [7:0]  pdiv[4] = '{8'h04, 8'h04, 8'h03, 8'h05};
    logic [7:0]  pcfg[4] = '{8'h80, 8'ha0, 8'h90, 8'h80};
    always #5 clk = ~clk;
    always @(posedge clk) begin
        osc_cnt  <= osc_cnt + 3'h1;
        fast_osc <= osc_cnt[1];
        slow_osc <= osc_cnt[2];
    end
    btsg_buzzer btsg_buzzer_inst (.clk(clk), .sys_rst(sys_rst), .fast_internal_osc(fast_osc),
        .slow_internal_osc(slow_osc), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .tone_output_pin(tone_output_pin), .irq(irq));
    btsg_buzzer_model btsg_buzzer_model_inst (.clk(clk), .sys_rst(sys_rst), .pin(tone_output_pin),
        .rises(rises), .period(period), .high_w(high_w));
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            fail_count++;
            end_sim();
        end
    endtask : tmo
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= {14'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin @(posedge clk); n++; end while ((s_axi_awready & s_axi_wready) !== 1'b1 && n < 50);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do begin @(posedge clk); n++; end while (s_axi_bvalid !== 1'b1 && n < 100);
        s_axi_bready <= 1'b0;
        tmo(n, 100);
        chk(32'(s_axi_bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [1:0] er, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= {14'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin @(posedge clk); n++; end while (s_axi_arready !== 1'b1 && n < 50);
        s_axi_arvalid <= 1'b0;
        do begin @(posedge clk); n++; end while (s_axi_rvalid !== 1'b1 && n < 100);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        tmo(n, 100);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : rd
    task automatic rc(input logic [15:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        rd(idx, RESP_OKAY, d);
        chk(d, {24'h0, exp});
    endtask : rc
    task automatic session(input logic [7:0] cfg, input logic [15:0] exp_rises);
        logic [31:0] d;
        logic [15:0] r0;
        int          n;
        r0 = rises;
        n = 0;
        wr(IDX_TONE_CONFIG_CONTROL, cfg | 8'h01, 4'h1, RESP_OKAY);
        rd(IDX_TONE_CONFIG_CONTROL, RESP_OKAY, d);
        chk(32'(d[CFG_GO_BUSY]), 32'h1);
        do begin rd(IDX_TONE_CONFIG_CONTROL, RESP_OKAY, d); n++; end while (d[0] !== 1'b0 && n < 2000);
        tmo(n, 2000);
        chk(32'(d[CFG_GO_BUSY]), 32'h0);
        chk(32'(rises - r0), 32'(exp_rises));
    endtask : session
    initial begin
        logic [31:0] d;
        logic [15:0] r0;
        int          n;
        int          dv;
        int          t;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 7; i++) rc(ri[i], rv[i]);
        chk(32'({irq, tone_output_pin}), 32'h0);
        wr(IDX_TONE_DIVISOR_LOW, 8'h55, 4'h0, RESP_OKAY);
        rc(IDX_TONE_DIVISOR_LOW, RST_TONE_DIVISOR);
        rd(16'ha12f, RESP_SLVERR, d);
        chk(d, 32'h0);
        wr(16'ha127, 8'h01, 4'h1, RESP_SLVERR);
        wr(IDX_TONE_DIVISOR_LOW, 8'h04, 4'h1, RESP_OKAY);
        wr(IDX_FRAME_PULSE_COUNTS, 8'h21, 4'h1, RESP_OKAY);
        wr(IDX_SESSION_FRAME_COUNT, 8'h02, 4'h1, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            wr(IDX_SESSION_MUTE_FRAME, mv[i], 4'h1, RESP_OKAY);
            session(8'hc0, (mv[i] == 8'h01) ? 16'd2 : (mv[i] == 8'h00) ? 16'd0 : 16'd4);
        end
        rc(IDX_TONE_CONFIG_CONTROL, 8'hc2);
        chk(32'(irq), 32'h0);
        wr(IDX_IRQ_MASK, 8'h01, 4'h1, RESP_OKAY);
        chk(32'(irq), 32'h1);
        rc(IDX_IRQ_STATUS, 8'h03);
        chk(32'(irq), 32'h0);
        rc(IDX_TONE_CONFIG_CONTROL, 8'hc2);
        wr(IDX_TONE_CONFIG_CONTROL, 8'hc0, 4'h1, RESP_OKAY);
        rc(IDX_TONE_CONFIG_CONTROL, 8'hc0);
        session(8'h80, 16'd4);
        rc(IDX_TONE_CONFIG_CONTROL, 8'h80);
        rd(IDX_IRQ_STATUS, RESP_OKAY, d);
        chk(d & 32'h1, 32'h0);
        wr(IDX_FRAME_PULSE_COUNTS, 8'h20, 4'h1, RESP_OKAY);
        wr(IDX_SESSION_FRAME_COUNT, 8'h01, 4'h1, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_TONE_DIVISOR_LOW, pdiv[i], 4'h1, RESP_OKAY);
            session(pcfg[i], 16'd2);
            dv = {pcfg[i][CFG_DIV8], pdiv[i]};
            t = pcfg[i][CFG_CSEL] ? SLOW_T : FAST_T;
            chk(32'(period), dv * t);
            chk(32'(high_w), ((dv + 1) / 2) * t);
        end
        wr(IDX_TONE_DIVISOR_LOW, 8'h04, 4'h1, RESP_OKAY);
        r0 = rises;
        n = 0;
        wr(IDX_TONE_CONFIG_CONTROL, 8'h85, 4'h1, RESP_OKAY);
        do begin @(posedge clk); n++; end while (16'(rises - r0) < 16'd8 && n < 2000);
        chk(32'(n < 2000), 32'h1);
        if (n >= 2000) begin
            end_sim();
        end
        rd(IDX_TONE_CONFIG_CONTROL, RESP_OKAY, d);
        chk(32'(d[CFG_GO_BUSY]), 32'h1);
        wr(IDX_TONE_CONFIG_CONTROL, 8'h00, 4'h1, RESP_OKAY);
        rc(IDX_TONE_CONFIG_CONTROL, 8'h00);
        repeat (3) @(posedge clk);
        chk(32'(tone_output_pin), 32'h0);
        wr(IDX_TONE_CONFIG_CONTROL, 8'h88, 4'h1, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk(32'(tone_output_pin), 32'h1);
        wr(IDX_TONE_CONFIG_CONTROL, 8'h00, 4'h1, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk(32'(tone_output_pin), 32'h0);
        end_sim();
    end
endmodule : btsg_buzzer_tb_top
`default_nettype wire
